// File: hdl/psg_pkg.sv
package psg_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_P3_LINK   = 8'h06;
  localparam logic [7:0] ADDR_STORM_LO  = 8'h07;
  localparam logic [7:0] ADDR_FT_A      = 8'h08;
  localparam logic [7:0] ADDR_FT_B      = 8'h09;
  localparam logic [7:0] ADDR_FT_C      = 8'h0A;

  // Field positions in port3_link_and_storm_high
  localparam int BIT_FC_EN    = 5;
  localparam int BIT_SPD_10M  = 4;
  localparam int BIT_NVID     = 3;
  localparam int STORM_HI_MSB = 2;
  localparam int STORM_LO_W   = 8;

  // Widths
  localparam int DATA_W   = 8;
  localparam int BUDGET_W = 11;
  localparam int TIMER_W  = 26;
  localparam int PORTS    = 3;

  // Reset values; strap-held bits take pin defaults
  localparam logic                RST_FC_EN   = 1'h1;
  localparam logic                RST_SPD_10M = 1'h0;
  localparam logic                RST_NVID    = 1'h0;
  localparam logic [BUDGET_W-1:0] RST_BUDGET  = 11'h063;
  localparam logic [DATA_W-1:0]   RD_ZERO     = 8'h00;

  // Fixed factory test values
  localparam logic [DATA_W-1:0] FT_A_VAL = 8'h00;
  localparam logic [DATA_W-1:0] FT_B_VAL = 8'h24;
  localparam logic [DATA_W-1:0] FT_C_VAL = 8'h35;

  // Storm interval timing
  localparam int CLK_MHZ        = 100;
  localparam int STORM_100_MS   = 67;
  localparam int STORM_10_MS    = 500;
  localparam int US_PER_MS      = 1000;
  localparam int STORM_100_CYC  = STORM_100_MS * US_PER_MS * CLK_MHZ;
  localparam int STORM_10_CYC   = STORM_10_MS * US_PER_MS * CLK_MHZ;

  typedef enum logic {
    PH_STRAP = 1'b0,
    PH_RUN   = 1'b1
  } psg_phase_t;

endpackage : psg_pkg

// File: hdl/psg_storm_meter.sv
`timescale 1ns/100ps
`default_nettype none
module psg_storm_meter
  import psg_pkg::*;
#(
  parameter int unsigned CYC_100 = STORM_100_CYC,
  parameter int unsigned CYC_10  = STORM_10_CYC
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Port state
  input  wire logic                i_speed_10m,
  input  wire logic                i_blk,
  input  wire logic [BUDGET_W-1:0] i_budget,
  // Status
  output logic                     o_drop,
  output logic [BUDGET_W-1:0]      o_count
);

  logic [TIMER_W-1:0]  timer_r;
  logic [TIMER_W-1:0]  timer_nxt;
  logic [BUDGET_W-1:0] count_r;
  logic [BUDGET_W-1:0] count_nxt;
  wire  [TIMER_W-1:0]  limit;
  wire                 wrap;
  wire                 drop;

  assign limit = i_speed_10m ? TIMER_W'(CYC_10 - 1) : TIMER_W'(CYC_100 - 1);
  assign wrap  = (timer_r >= limit);
  assign drop  = (count_r >= i_budget);

  assign timer_nxt = wrap ? '0 : timer_r + TIMER_W'(1);
  assign count_nxt = wrap ? '0 :
                     (i_blk && !drop) ? count_r + BUDGET_W'(1) : count_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_r <= '0;
      count_r <= '0;
    end else begin
      timer_r <= timer_nxt;
      count_r <= count_nxt;
    end
  end

  assign o_drop  = drop;
  assign o_count = count_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  interval_restart_a : assert property (wrap |=> count_r == '0)
    else $error("Block count not cleared at interval end");
  over_budget_a : assert property (i_blk && drop && !wrap |=>
                                   count_r == $past(count_r))
    else $error("Block counted while port discarding");
  block_counted_a : assert property (i_blk && !drop && !wrap |=>
                                     count_r == $past(count_r) + 1)
    else $error("Accepted block not counted");

endmodule : psg_storm_meter
`default_nettype wire

// File: hdl/psg_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Register 0x06 bit 5 enables port 3 full-duplex pause flow control.
// - Flow-control bit loads from its strap pin at reset; default enabled.
// - Register 0x06 bit 4 selects 10 Mbps, clear selects 100 Mbps.
// - Speed bit loads from its strap pin at reset; default 100 Mbps.
// - Register 0x06 bit 3 enables null VLAN ID replacement.
// - Storm budget is 0x06 bits 2:0 over 0x07, in 64-byte blocks.
// - Storm interval is 67 ms at 100 Mbps, 500 ms at 10 Mbps.
// - Storm budget resets to 0x63.
// - Test registers 0x08-0x0A read 0x00, 0x24, 0x35; writes ignored.
module psg_ctrl
  import psg_pkg::*;
#(
  parameter int unsigned STORM_CYC_100 = STORM_100_CYC,
  parameter int unsigned STORM_CYC_10  = STORM_10_CYC
) (
  // Clock and reset
  input  wire logic                I_REF_CLK,
  input  wire logic                I_SYS_RST,
  // Strap pins
  input  wire logic                I_FLOW_CTRL_STRAP_PIN,
  input  wire logic                I_UPLINK_SPEED_STRAP_PIN,
  // Register port
  input  wire logic [7:0]          I_REG_ADDR,
  input  wire logic                I_REG_WR,
  input  wire logic [DATA_W-1:0]   I_REG_WDATA,
  input  wire logic                I_REG_RD,
  output logic [DATA_W-1:0]        O_REG_RDATA,
  // Port 3 link controls
  output logic                     O_P3_FLOW_CTRL_EN,
  output logic                     O_P3_SPEED_10M,
  output logic                     O_NULL_VID_REPLACE_EN,
  output logic [BUDGET_W-1:0]      O_STORM_BUDGET,
  // Broadcast storm metering
  input  wire logic [1:0]          I_PHY_SPEED_10M,
  input  wire logic [PORTS-1:0]    I_BCAST_BLK,
  output logic [PORTS-1:0]         O_BCAST_DISCARD
);

  psg_phase_t                phase_r;
  psg_phase_t                phase_nxt;
  logic                      fc_en_r;
  logic                      fc_en_nxt;
  logic                      spd_10m_r;
  logic                      spd_10m_nxt;
  logic                      nvid_r;
  logic                      nvid_nxt;
  logic [BUDGET_W-1:0]       budget_r;
  logic [BUDGET_W-1:0]       budget_nxt;
  logic [DATA_W-1:0]         rdata_r;
  logic [DATA_W-1:0]         rdata_nxt;

  wire                       run;
  wire                       wr_link;
  wire                       wr_lo;
  wire [DATA_W-1:0]          link_rd;
  wire [PORTS-1:0]           port_10m;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Writes wait until straps are caught, so no write races the load
  assign run     = (phase_r == PH_RUN);
  assign wr_link = run && I_REG_WR && hit(I_REG_ADDR, ADDR_P3_LINK);
  assign wr_lo   = run && I_REG_WR && hit(I_REG_ADDR, ADDR_STORM_LO);

  assign phase_nxt = PH_RUN;

  assign fc_en_nxt   = !run   ? I_FLOW_CTRL_STRAP_PIN :
                       wr_link ? I_REG_WDATA[BIT_FC_EN] : fc_en_r;
  assign spd_10m_nxt = !run   ? I_UPLINK_SPEED_STRAP_PIN :
                       wr_link ? I_REG_WDATA[BIT_SPD_10M] : spd_10m_r;
  assign nvid_nxt    = wr_link ? I_REG_WDATA[BIT_NVID] : nvid_r;
  assign budget_nxt  = {wr_link ? I_REG_WDATA[STORM_HI_MSB:0]
                                : budget_r[BUDGET_W-1:STORM_LO_W],
                        wr_lo   ? I_REG_WDATA
                                : budget_r[STORM_LO_W-1:0]};

  assign link_rd = {2'h0, fc_en_r, spd_10m_r, nvid_r,
                    budget_r[BUDGET_W-1:STORM_LO_W]};

  assign rdata_nxt = !I_REG_RD                      ? rdata_r :
                     hit(I_REG_ADDR, ADDR_P3_LINK)  ? link_rd :
                     hit(I_REG_ADDR, ADDR_STORM_LO) ? budget_r[STORM_LO_W-1:0] :
                     hit(I_REG_ADDR, ADDR_FT_A)     ? FT_A_VAL :
                     hit(I_REG_ADDR, ADDR_FT_B)     ? FT_B_VAL :
                     hit(I_REG_ADDR, ADDR_FT_C)     ? FT_C_VAL : RD_ZERO;

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      phase_r   <= PH_STRAP;
      fc_en_r   <= RST_FC_EN;
      spd_10m_r <= RST_SPD_10M;
      nvid_r    <= RST_NVID;
      budget_r  <= RST_BUDGET;
      rdata_r   <= RD_ZERO;
    end else begin
      phase_r   <= phase_nxt;
      fc_en_r   <= fc_en_nxt;
      spd_10m_r <= spd_10m_nxt;
      nvid_r    <= nvid_nxt;
      budget_r  <= budget_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign O_P3_FLOW_CTRL_EN     = fc_en_r;
  assign O_P3_SPEED_10M        = spd_10m_r;
  assign O_NULL_VID_REPLACE_EN = nvid_r;
  assign O_STORM_BUDGET        = budget_r;
  assign O_REG_RDATA           = rdata_r;

  // Port 3 follows its own speed bit, ports 1 and 2 their PHYs
  assign port_10m = {spd_10m_r, I_PHY_SPEED_10M};

  genvar gp;
  generate
    for (gp = 0; gp < PORTS; gp++) begin : g_meter
      psg_storm_meter #(
        .CYC_100 (STORM_CYC_100),
        .CYC_10  (STORM_CYC_10)
      ) u_meter (
        .i_clk       (I_REF_CLK),
        .i_rst       (I_SYS_RST),
        .i_speed_10m (port_10m[gp]),
        .i_blk       (I_BCAST_BLK[gp]),
        .i_budget    (budget_r),
        .o_drop      (O_BCAST_DISCARD[gp]),
        .o_count     ()
      );
    end
  endgenerate

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  // Release edge itself still resets the flops, so need sampled reset low
  sequence s_strap_phase;
    !I_SYS_RST && phase_r == PH_STRAP;
  endsequence
  sequence s_strap_loaded;
    O_P3_FLOW_CTRL_EN == $past(I_FLOW_CTRL_STRAP_PIN) &&
    O_P3_SPEED_10M == $past(I_UPLINK_SPEED_STRAP_PIN);
  endsequence

  strap_load_a : assert property (s_strap_phase |=> s_strap_loaded)
    else $error("Strap levels not loaded after reset");
  speed_strap_a : assert property (s_strap_phase |=>
    O_P3_SPEED_10M == $past(I_UPLINK_SPEED_STRAP_PIN))
    else $error("Speed strap not loaded");
  budget_reset_a : assert property (s_strap_phase |->
                                    O_STORM_BUDGET == RST_BUDGET)
    else $error("Storm budget reset value wrong");
  flow_write_a : assert property (wr_link |=>
    O_P3_FLOW_CTRL_EN == $past(I_REG_WDATA[BIT_FC_EN]))
    else $error("Flow control bit not written");
  speed_write_a : assert property (wr_link |=>
    O_P3_SPEED_10M == $past(I_REG_WDATA[BIT_SPD_10M]))
    else $error("Speed bit not written");
  nvid_write_a : assert property (wr_link |=>
    O_NULL_VID_REPLACE_EN == $past(I_REG_WDATA[BIT_NVID]))
    else $error("Null VID bit not written");
  budget_join_a : assert property (wr_lo && !wr_link |=>
    O_STORM_BUDGET == {$past(budget_r[BUDGET_W-1:STORM_LO_W]),
                       $past(I_REG_WDATA)})
    else $error("Storm budget low byte not joined");
  test_read_a : assert property (I_REG_RD &&
    hit(I_REG_ADDR, ADDR_FT_B) |=> O_REG_RDATA == FT_B_VAL)
    else $error("Factory test register read wrong");
  discard_tie_a : assert property ($rose(O_BCAST_DISCARD[PORTS-1]) |->
    $past(I_BCAST_BLK[PORTS-1] || wr_link || wr_lo))
    else $error("Discard without block or budget change");
  interval_len_a : assert property (!port_10m[0] &&
    g_meter[0].u_meter.timer_r == TIMER_W'(STORM_CYC_100 - 1) |=>
    g_meter[0].u_meter.timer_r == TIMER_W'(0))
    else $error("Interval did not end at its length");
  interval_step_a : assert property (!I_SYS_RST && !port_10m[0] &&
    g_meter[0].u_meter.timer_r < TIMER_W'(STORM_CYC_100 - 1) |=>
    g_meter[0].u_meter.timer_r ==
    $past(g_meter[0].u_meter.timer_r) + 1)
    else $error("Interval ended early");

endmodule : psg_ctrl
`default_nettype wire

// File: test/psg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module psg_host_model
  import psg_pkg::*;
(
  // Clock
  input  wire logic              i_clk,
  // Register port
  output logic [7:0]             o_addr,
  output logic                   o_wr,
  output logic [DATA_W-1:0]      o_wdata,
  output logic                   o_rd,
  input  wire logic [DATA_W-1:0] i_rdata
);
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
    o_rd    = 1'b0;
  end

  // Released lines show inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : psg_host_model
`default_nettype wire

// File: test/test_switch_port3_storm_global_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("mismatch at %0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module test_switch_port3_storm_global_ctrl;
  import psg_pkg::*;
  localparam int C100 = 50;
  localparam int C10  = 200;
  logic                clk, rst, fc_pin, spd_pin, wr, rd;
  logic                fc_en, spd_10m, nvid;
  logic [7:0]          addr;
  logic [DATA_W-1:0]   wdata, rdata, rv;
  logic [BUDGET_W-1:0] budget;
  logic [1:0]          phy_10m;
  logic [PORTS-1:0]    blk, discard;
  logic [7:0]          ft_addr [4] = '{8'h08, 8'h09, 8'h0A, 8'h0B};
  logic [7:0]          ft_val  [4] = '{8'h00, 8'h24, 8'h35, 8'h00};
  int                  failures = 0;
  int                  comparisons = 0;

  psg_ctrl #(.STORM_CYC_100(C100), .STORM_CYC_10(C10)) psg_ctrl_inst (
    .I_REF_CLK(clk), .I_SYS_RST(rst),
    .I_FLOW_CTRL_STRAP_PIN(fc_pin), .I_UPLINK_SPEED_STRAP_PIN(spd_pin),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd),
    .O_REG_RDATA(rdata), .O_P3_FLOW_CTRL_EN(fc_en), .O_P3_SPEED_10M(spd_10m),
    .O_NULL_VID_REPLACE_EN(nvid), .O_STORM_BUDGET(budget),
    .I_PHY_SPEED_10M(phy_10m), .I_BCAST_BLK(blk), .O_BCAST_DISCARD(discard));

  psg_host_model psg_host_model_inst (
    .i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
    .i_rdata(rdata));

  task automatic wrap_up;
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic pulse(input int p);
    @(posedge clk);
    blk[p] <= 1'b1;
    @(posedge clk);
    blk[p] <= 1'b0;
    @(negedge clk);
  endtask : pulse

  // Period measured fall to fall, so timer phase does not matter
  task automatic storm(input int p, input int per);
    int n;
    n = 0;
    while (discard[p] !== 1'b1 && n < 20) begin
      pulse(p);
      n++;
    end
    n = 0;
    while (discard[p] !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    pulse(p);
    pulse(p);
    `CHK(discard[p], 1'b1)
    n = 4;
    while (discard[p] !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, per)
  endtask : storm

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    rst     <= 1'b1;
    fc_pin  <= 1'b0;
    spd_pin <= 1'b1;
    phy_10m <= 2'b10;
    blk     <= 3'b000;
    repeat (10) @(posedge clk);
    @(negedge clk);
    `CHK(budget, 11'h063)
    `CHK({fc_en, spd_10m, nvid}, 3'b100)
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK({fc_en, spd_10m}, 2'b01)
    psg_host_model_inst.rd(ADDR_P3_LINK, rv);
    `CHK(rv, 8'h10)
    psg_host_model_inst.rd(ADDR_STORM_LO, rv);
    `CHK(rv, 8'h63)
    psg_host_model_inst.wr(ADDR_P3_LINK, 8'hFF);
    @(negedge clk);
    `CHK({fc_en, spd_10m, nvid, budget}, {3'b111, 11'h763})
    psg_host_model_inst.rd(ADDR_P3_LINK, rv);
    `CHK(rv, 8'h3F)
    psg_host_model_inst.wr(ADDR_P3_LINK, 8'h05);
    psg_host_model_inst.wr(ADDR_STORM_LO, 8'hA5);
    @(negedge clk);
    `CHK({fc_en, spd_10m, nvid, budget}, {3'b000, 11'h5A5})
    for (int i = 0; i < 4; i++) begin
      psg_host_model_inst.wr(ft_addr[i], 8'hFF);
      psg_host_model_inst.rd(ft_addr[i], rv);
      `CHK(rv, ft_val[i])
    end
    `CHK(budget, 11'h5A5)
    psg_host_model_inst.wr(ADDR_P3_LINK, 8'h10);
    psg_host_model_inst.wr(ADDR_STORM_LO, 8'h02);
    storm(0, C100);
    storm(1, C10);
    storm(2, C10);
    psg_host_model_inst.wr(ADDR_P3_LINK, 8'h00);
    storm(2, C100);
    wrap_up();
  end
endmodule : test_switch_port3_storm_global_ctrl
`default_nettype wire
